// ### stg_motor_model.sv
// Behavioural model of the driven motor and its speed feedback.
`timescale 1ns/1ps
`default_nettype none
module stg_motor_model #(
   parameter logic [15:0] EST_RATIO = 16'h000c
) (
   input wire logic sys_clk,
   input wire logic loadHeld,
   input wire logic freqFloor,
   input wire logic accelCmd,
   output logic [15:0] motorSpeed,
   output logic [15:0] outputTorque,
   output logic [15:0] outputFreq,
   output logic stallPrevActive,
   output logic accelActive,
   output logic [15:0] estInertia,
   output logic estValid
);
   // ======================================================================
   // A held shaft creeps while pushing torque; a floor pins the frequency.
   logic [1:0] phase = 2'h0;
   always @(posedge sys_clk) phase <= phase + 2'h1;
   assign motorSpeed = loadHeld ? 16'h0004 : 16'h0200;
   assign outputTorque = loadHeld ? 16'h0100 : 16'h0040;
   assign outputFreq = freqFloor ? 16'h0032 : 16'h1388;
   assign stallPrevActive = freqFloor;
   assign accelActive = accelCmd;
   // The estimate is fresh only every fourth cycle, and shows the phase count otherwise.
   assign estValid = accelCmd && phase == 2'h3;
   assign estInertia = estValid ? EST_RATIO : {14'h0, phase};
endmodule
`default_nettype wire

// ### stg_regs.vh
// Register indices, field values, reset values and timing constants of the stall and gain block.
`ifndef STG_REGS_VH
`define STG_REGS_VH
// ======================================================================
// Register indices
`define STG_ADDR_RESP 4'h0
`define STG_ADDR_MODE 4'h1
`define STG_ADDR_PG1 4'h2
`define STG_ADDR_IT1 4'h3
`define STG_ADDR_PG2 4'h4
`define STG_ADDR_IT2 4'h5
`define STG_ADDR_INERTIA 4'h6
`define STG_ADDR_STALLTQ 4'h7
`define STG_ADDR_LOWSPD 4'h8
`define STG_ADDR_WPOL 4'h9
`define STG_ADDR_CTRL 4'ha
`define STG_ADDR_STATUS 4'hb
`define STG_ADDR_ACTPG 4'hc
`define STG_ADDR_ACTIT 4'hd
// ======================================================================
// Reset values and limits
`define STG_RESP_RST 16'h0002
`define STG_RESP_MIN 16'h0001
`define STG_RESP_MAX 16'h000f
`define STG_MODE_OFF 16'h0000
`define STG_MODE_AUTO 16'h0001
`define STG_MODE_MANUAL 16'h0002
`define STG_PG_RST 16'h003c
`define STG_PG_MAX 16'h03e8
`define STG_IT_RST 16'h014d
`define STG_IT_MAX 16'h4e20
`define STG_SECOND_OFF 16'h270f
`define STG_INERTIA_RST 16'h0007
`define STG_INERTIA_MAX 16'h00c8
`define STG_WPOL_RUNWRITE 16'h0002
`define STG_FLOOR_FREQ 16'h0032
// ======================================================================
// Control modes (drive method and loop) in the control register
`define STG_DRV_VF 2'h0
`define STG_DRV_AFV 2'h1
`define STG_DRV_RSV 2'h2
`define STG_DRV_VEC 2'h3
`define STG_LOOP_SPEED 2'h0
`define STG_LOOP_TORQUE 2'h1
`define STG_LOOP_POS 2'h2
// ======================================================================
// Timing
`define STG_QUAL_MS 3000
`define STG_CLK_HZ 25000000
`endif

// ### stg_stall_gain.v
// Stall trip supervisor and easy gain tuning register block.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// R01: Trip when speed below threshold and torque above stall level for 3 s.
// R02: Under V/F or flux vector, trip when stall holds frequency at 0.5 Hz 3 s.
// R03: Never trip while in torque control.
// R04: Response level accepts 1 to 15, default 2.
// R05: Tuning select decodes 0 off, 1 auto estimation, 2 manual inertia.
// R06: First proportional gain accepts 0 to 1000 percent, resets to 60.
// R07: First integral time accepts 0 to 20 s, resets to 0.333 s.
// R08: Second gains replace first while select input high; 9999 disables them.
// R09: Load inertia ratio accepts 0 to 200, resets to 7.
// R10: Auto estimation runs only in speed or position under vector control.
// R11: Auto estimation starts from stored ratio and writes estimate back; no port passes the stored ratio to the estimator.
// R12: Gains are set from estimated inertia and response level.
// R13: Manual tuning applies only in sensorless speed or vector speed/position.
// R14: Selecting 2 computes and stores first gains; used from the next run.
// R15: Response level changes while running only when write policy is 2.
// R16: Returning selection to 0 keeps tuned gains unchanged.
// R17: A forward or reverse run lets estimation or gain calculation proceed.
// R18: The stall timer clears whenever the qualifying condition lapses.
// The constants must be known before the parameter list uses them.
`include "stg_regs.vh"
module stg_stall_gain #(
   parameter QUAL_CYCLES = (`STG_CLK_HZ / 1000) * `STG_QUAL_MS
) (
   input wire sys_clk,
   input wire rstn,
   input wire [3:0] regAddr,
   input wire [15:0] regWdata,
   input wire regWr,
   input wire regRd,
   output reg [15:0] regRdata,
   input wire forward_run_input,
   input wire reverse_run_input,
   input wire forward_run_key,
   input wire reverse_run_key,
   input wire second_gain_select,
   input wire [15:0] motorSpeed,
   input wire [15:0] outputTorque,
   input wire [15:0] outputFreq,
   input wire stallPrevActive,
   input wire accelActive,
   input wire [15:0] estInertia,
   input wire estValid,
   output reg stall_trip_fault,
   output reg [15:0] activePropGain,
   output reg [15:0] activeIntegralTime,
   output reg estimating
);
   // ======================================================================
   // Registers
   reg [15:0] tuning_response_level;
   reg [15:0] tuning_mode_select;
   reg [15:0] speed_prop_gain_first;
   reg [15:0] speed_integral_time_first;
   reg [15:0] speed_prop_gain_second;
   reg [15:0] speed_integral_time_second;
   reg [15:0] load_inertia_ratio;
   reg [15:0] stall_torque_level;
   reg [15:0] low_speed_threshold;
   reg [15:0] param_write_policy;
   reg [1:0] driveMethod;
   reg [1:0] loopMode;
   reg [31:0] qualCount;
   reg calcPending;
   reg [15:0] pendPg;
   reg [15:0] pendIt;
   // ======================================================================
   // Pin synchronisers: two flops before any logic reads the run inputs.
   reg [3:0] runMeta;
   reg [3:0] runSync;
   reg selMeta;
   reg selSync;
   always @(posedge sys_clk) begin
      if (!rstn) begin
         runMeta <= 4'h0;
         runSync <= 4'h0;
         selMeta <= 1'b0;
         selSync <= 1'b0;
      end else begin
         runMeta <= {forward_run_input, reverse_run_input, forward_run_key, reverse_run_key};
         runSync <= runMeta;
         selMeta <= second_gain_select;
         selSync <= selMeta;
      end
   end
   // ======================================================================
   // Mode decode.
   wire running = |runSync; // R17
   wire torqueMode = (loopMode == `STG_LOOP_TORQUE);
   wire speedOrPos = (loopMode == `STG_LOOP_SPEED) || (loopMode == `STG_LOOP_POS);
   wire vecCtl = (driveMethod == `STG_DRV_VEC);
   wire autoOk = vecCtl && speedOrPos; // R10
   wire manualOk = autoOk || ((driveMethod == `STG_DRV_RSV) &&
                   (loopMode == `STG_LOOP_SPEED)); // R13
   wire modeAuto = (tuning_mode_select == `STG_MODE_AUTO); // R05
   wire modeManual = (tuning_mode_select == `STG_MODE_MANUAL); // R05
   wire freqFloor = (driveMethod == `STG_DRV_VF) || (driveMethod == `STG_DRV_AFV);
   // Gain math: proportional gain scales with inertia and response level.
   // Kept coarse on purpose; a divider here would cost far more than it buys.
   function [15:0] calcPg;
      input [15:0] inertia;
      input [15:0] resp;
      reg [31:0] p;
      begin
         p = (({16'h0000, inertia} + 32'h00000001) * {16'h0000, resp}) * 32'h0000000a;
         calcPg = (p > {16'h0000, `STG_PG_MAX}) ? `STG_PG_MAX : p[15:0];
      end
   endfunction
   // Integral time falls as the response level rises.
   function [15:0] calcIt;
      input [15:0] inertia;
      input [15:0] resp;
      reg [31:0] t;
      begin
         t = ({16'h0000, `STG_IT_RST} * 32'h00000002) / ({16'h0000, resp} + 32'h00000001);
         t = t + {16'h0000, inertia};
         calcIt = (t > {16'h0000, `STG_IT_MAX}) ? `STG_IT_MAX : t[15:0];
      end
   endfunction
   function inRange;
      input [15:0] v;
      input [15:0] lo;
      input [15:0] hi;
      begin
         inRange = (v >= lo) && (v <= hi);
      end
   endfunction
   wire wrHit = regWr;
   // ======================================================================
   // Register writes and tuning updates.
   always @(posedge sys_clk) begin
      if (!rstn) begin
         tuning_response_level <= `STG_RESP_RST; // R04
         tuning_mode_select <= `STG_MODE_OFF;
         speed_prop_gain_first <= `STG_PG_RST; // R06
         speed_integral_time_first <= `STG_IT_RST; // R07
         speed_prop_gain_second <= `STG_SECOND_OFF; // R08
         speed_integral_time_second <= `STG_SECOND_OFF; // R08
         load_inertia_ratio <= `STG_INERTIA_RST; // R09
         stall_torque_level <= 16'h0000;
         low_speed_threshold <= 16'h0000;
         param_write_policy <= 16'h0000;
         driveMethod <= `STG_DRV_VEC;
         loopMode <= `STG_LOOP_SPEED;
         calcPending <= 1'b0;
         pendPg <= 16'h0000;
         pendIt <= 16'h0000;
      end else begin
         // Manual gains computed at select time go live only once stopped.
         if (calcPending && !running) begin
            speed_prop_gain_first <= pendPg; // R14
            speed_integral_time_first <= pendIt; // R14
            calcPending <= 1'b0;
         end
         // Auto estimation writes estimate and gains back during the run.
         if (modeAuto && autoOk && running && accelActive && estValid) begin
            load_inertia_ratio <= (estInertia > `STG_INERTIA_MAX) ?
                                  `STG_INERTIA_MAX : estInertia; // R11
            speed_prop_gain_first <= calcPg(estInertia, tuning_response_level); // R12
            speed_integral_time_first <= calcIt(estInertia, tuning_response_level); // R12
         end
         if (wrHit) begin
            case (regAddr)
               `STG_ADDR_RESP: begin
                  if (inRange(regWdata, `STG_RESP_MIN, `STG_RESP_MAX) &&
                      (!running || param_write_policy == `STG_WPOL_RUNWRITE)) begin
                     tuning_response_level <= regWdata; // R04 R15
                  end
               end
               `STG_ADDR_MODE: begin
                  // Going to off leaves tuned gains alone.
                  if (regWdata <= `STG_MODE_MANUAL) begin
                     tuning_mode_select <= regWdata; // R05 R16
                     if (regWdata == `STG_MODE_MANUAL && manualOk) begin
                        pendPg <= calcPg(load_inertia_ratio, tuning_response_level); // R14
                        pendIt <= calcIt(load_inertia_ratio, tuning_response_level); // R14
                        calcPending <= 1'b1;
                     end
                  end
               end
               `STG_ADDR_PG1: begin
                  if (regWdata <= `STG_PG_MAX && tuning_mode_select == `STG_MODE_OFF) begin
                     speed_prop_gain_first <= regWdata; // R06
                  end
               end
               `STG_ADDR_IT1: begin
                  if (regWdata <= `STG_IT_MAX && tuning_mode_select == `STG_MODE_OFF) begin
                     speed_integral_time_first <= regWdata; // R07
                  end
               end
               `STG_ADDR_PG2: begin
                  if (regWdata <= `STG_PG_MAX || regWdata == `STG_SECOND_OFF) begin
                     speed_prop_gain_second <= regWdata; // R08
                  end
               end
               `STG_ADDR_IT2: begin
                  if (regWdata <= `STG_IT_MAX || regWdata == `STG_SECOND_OFF) begin
                     speed_integral_time_second <= regWdata; // R08
                  end
               end
               `STG_ADDR_INERTIA: begin
                  if (regWdata <= `STG_INERTIA_MAX && !(modeAuto && running)) begin
                     load_inertia_ratio <= regWdata; // R09
                  end
               end
               `STG_ADDR_STALLTQ: stall_torque_level <= regWdata;
               `STG_ADDR_LOWSPD: low_speed_threshold <= regWdata;
               `STG_ADDR_WPOL: param_write_policy <= regWdata;
               `STG_ADDR_CTRL: begin
                  driveMethod <= regWdata[1:0];
                  loopMode <= regWdata[3:2];
               end
               default: begin
               end
            endcase
         end
      end
   end
   // ======================================================================
   // Stall qualification timer; any lapse restarts the interval.
   wire torqueStall = (motorSpeed < low_speed_threshold) &&
                      (outputTorque > stall_torque_level); // R01
   wire freqStall = freqFloor && stallPrevActive &&
                    (outputFreq <= `STG_FLOOR_FREQ); // R02
   wire stallCond = !torqueMode && (torqueStall || freqStall); // R03
   always @(posedge sys_clk) begin
      if (!rstn) begin
         qualCount <= 32'h00000000;
         stall_trip_fault <= 1'b0;
      end else begin
         if (!stallCond) begin
            qualCount <= 32'h00000000; // R18
         end else if (qualCount < QUAL_CYCLES) begin
            qualCount <= qualCount + 32'h00000001;
         end
         // The trip latches until reset, like a real drive fault.
         if (stallCond && qualCount >= QUAL_CYCLES - 1) begin
            stall_trip_fault <= 1'b1; // R01 R02
         end
      end
   end
   // ======================================================================
   // Active gains and estimator status.
   always @(posedge sys_clk) begin
      if (!rstn) begin
         activePropGain <= `STG_PG_RST;
         activeIntegralTime <= `STG_IT_RST;
         estimating <= 1'b0;
      end else begin
         activePropGain <= (selSync && speed_prop_gain_second != `STG_SECOND_OFF) ?
                           speed_prop_gain_second : speed_prop_gain_first; // R08
         activeIntegralTime <= (selSync && speed_integral_time_second != `STG_SECOND_OFF) ?
                               speed_integral_time_second : speed_integral_time_first; // R08
         estimating <= modeAuto && autoOk && running; // R10 R17
      end
   end
   // ======================================================================
   // Read data stands in the cycle after the strobe only.
   always @(posedge sys_clk) begin
      if (!rstn) begin
         regRdata <= 16'h0000;
      end else if (regRd) begin
         case (regAddr)
            `STG_ADDR_RESP: regRdata <= tuning_response_level;
            `STG_ADDR_MODE: regRdata <= tuning_mode_select;
            `STG_ADDR_PG1: regRdata <= speed_prop_gain_first;
            `STG_ADDR_IT1: regRdata <= speed_integral_time_first;
            `STG_ADDR_PG2: regRdata <= speed_prop_gain_second;
            `STG_ADDR_IT2: regRdata <= speed_integral_time_second;
            `STG_ADDR_INERTIA: regRdata <= load_inertia_ratio;
            `STG_ADDR_STALLTQ: regRdata <= stall_torque_level;
            `STG_ADDR_LOWSPD: regRdata <= low_speed_threshold;
            `STG_ADDR_WPOL: regRdata <= param_write_policy;
            `STG_ADDR_CTRL: regRdata <= {12'h000, loopMode, driveMethod};
            `STG_ADDR_STATUS: regRdata <= {12'h000, calcPending, running, estimating,
                                           stall_trip_fault};
            `STG_ADDR_ACTPG: regRdata <= activePropGain;
            `STG_ADDR_ACTIT: regRdata <= activeIntegralTime;
            default: regRdata <= 16'h0000;
         endcase
      end else begin
         regRdata <= 16'h0000;
      end
   end
endmodule
`default_nettype wire

// ### stg_stall_gain_properties.sv
// Concurrent checks on the ports of the stall trip and gain tuning block.
`timescale 1ns/1ps
`default_nettype none
`include "stg_regs.vh"
module stg_stall_gain_checker #(
   parameter QUAL_CYCLES = 20
) (
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [3:0] regAddr,
   input wire logic [15:0] regWdata,
   input wire logic regWr,
   input wire logic regRd,
   input wire logic [15:0] regRdata,
   input wire logic second_gain_select,
   input wire logic [15:0] motorSpeed,
   input wire logic [15:0] outputTorque,
   input wire logic [15:0] outputFreq,
   input wire logic stallPrevActive,
   input wire logic stall_trip_fault,
   input wire logic [15:0] activePropGain,
   input wire logic [15:0] activeIntegralTime,
   input wire logic estimating
);
   // ======================================================================
   // Shadow registers, so that the properties know thresholds and modes.
   logic [15:0] lowSpd, stallTq, pg2, it2, mode;
   logic [3:0] ctrl;
   logic [31:0] qualCnt;
   wire logic [1:0] loopSel = ctrl[3:2];
   wire logic wrOn = regWr && rstn;
   wire logic autoOk = mode == `STG_MODE_AUTO && ctrl[1:0] == `STG_DRV_VEC && loopSel != 2'h1;
   wire logic floorHit = ctrl[1:0] <= `STG_DRV_AFV && stallPrevActive && outputFreq <= 16'h0032;
   wire logic slowHard = motorSpeed < lowSpd && outputTorque > stallTq;
   wire logic stallCond = loopSel != `STG_LOOP_TORQUE && (floorHit || slowHard);
   // One clear cycle restarts the count, so only an unbroken interval trips.
   always_ff @(posedge sys_clk) begin
      qualCnt <= (rstn && stallCond) ? qualCnt + 32'h1 : 32'h0;
      if (!rstn) begin
         {lowSpd, stallTq, mode, ctrl} <= {32'h0, `STG_MODE_OFF, 4'h3};
         {pg2, it2} <= {`STG_SECOND_OFF, `STG_SECOND_OFF};
      end
      if (wrOn && regAddr == `STG_ADDR_LOWSPD) lowSpd <= regWdata;
      if (wrOn && regAddr == `STG_ADDR_STALLTQ) stallTq <= regWdata;
      if (wrOn && regAddr == `STG_ADDR_CTRL) ctrl <= regWdata[3:0];
      if (wrOn && regAddr == `STG_ADDR_MODE && regWdata <= `STG_MODE_MANUAL) mode <= regWdata;
      if (wrOn && regAddr == `STG_ADDR_PG2 && (regWdata <= `STG_PG_MAX || regWdata == 16'h270f))
         pg2 <= regWdata;
      if (wrOn && regAddr == `STG_ADDR_IT2 && (regWdata <= `STG_IT_MAX || regWdata == 16'h270f))
         it2 <= regWdata;
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);
   sequence selHeld;
      second_gain_select [*5];
   endsequence
   // ======================================================================
   // Stall supervisor: not early, not late, never in torque loop, latched.
   stall_not_early_a: assert property ($rose(stall_trip_fault) |-> qualCnt >= QUAL_CYCLES)
      else $error("stall trip before a full qualifying interval");
   stall_not_late_a: assert property (qualCnt == QUAL_CYCLES + 2 |-> stall_trip_fault)
      else $error("stall trip missing after qualifying interval");
   torque_no_trip_a: assert property ($rose(stall_trip_fault) |-> $past(loopSel) != 2'h1)
      else $error("stall trip raised in torque loop");
   fault_held_a: assert property (stall_trip_fault |=> stall_trip_fault)
      else $error("stall trip fault dropped without reset");
   // Gains, estimation and the register port.
   reset_gains_a: assert property ($rose(rstn) |-> activePropGain == 16'h003c &&
      activeIntegralTime == 16'h014d && !stall_trip_fault)
      else $error("wrong active values after reset");
   second_prop_a: assert property (selHeld ##0 pg2 != 16'h270f |-> activePropGain == pg2)
      else $error("second proportional gain not in use");
   second_int_a: assert property (selHeld ##0 it2 != 16'h270f |-> activeIntegralTime == it2)
      else $error("second integral time not in use");
   est_gate_a: assert property (estimating |-> $past(autoOk))
      else $error("estimation active outside vector speed or position");
   read_idle_a: assert property (!$past(regRd) |-> regRdata == 16'h0000)
      else $error("read data outside the answer cycle");
   read_second_a: assert property (regRd && regAddr == 4'h4 |=> regRdata == pg2)
      else $error("second gain read back wrong");
endmodule
bind stg_stall_gain stg_stall_gain_checker #(.QUAL_CYCLES(QUAL_CYCLES)) i_stg_stall_gain_checker (
   .sys_clk, .rstn, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .second_gain_select,
   .motorSpeed, .outputTorque, .outputFreq, .stallPrevActive, .stall_trip_fault,
   .activePropGain, .activeIntegralTime, .estimating);
`default_nettype wire

// ### tb_stg_stall_gain.sv
// Self-checking bench for the stall trip and gain tuning block.
`timescale 1ns/1ps
`default_nettype none
`include "stg_regs.vh"
module tb_stg_stall_gain;
   localparam int QUAL = 20;
   logic sys_clk = 0, rstn = 0, regWr = 0, regRd = 0, second_gain_select = 0;
   logic forward_run_input = 0, reverse_run_input = 0, forward_run_key = 0, reverse_run_key = 0;
   logic held = 0, floorOn = 0, accel = 0;
   logic [3:0] regAddr = 4'h0;
   logic [15:0] regWdata = 16'h0, v, keep;
   wire [15:0] regRdata, motorSpeed, outputTorque, outputFreq, estInertia;
   wire [15:0] activePropGain, activeIntegralTime;
   wire stallPrevActive, accelActive, estValid, stall_trip_fault, estimating;
   int n_fail = 0, samples_checked = 0;
   stg_stall_gain #(.QUAL_CYCLES(QUAL)) i_stg_stall_gain (.sys_clk, .rstn, .regAddr, .regWdata,
      .regWr, .regRd, .regRdata, .forward_run_input, .reverse_run_input, .forward_run_key,
      .reverse_run_key, .second_gain_select, .motorSpeed, .outputTorque, .outputFreq,
      .stallPrevActive, .accelActive, .estInertia, .estValid, .stall_trip_fault,
      .activePropGain, .activeIntegralTime, .estimating);
   stg_motor_model i_stg_motor_model (.sys_clk, .loadHeld(held), .freqFloor(floorOn),
      .accelCmd(accel), .motorSpeed, .outputTorque, .outputFreq, .stallPrevActive,
      .accelActive, .estInertia, .estValid);
   initial forever #20 sys_clk = ~sys_clk;
   // ======================================================================
   // Shared bus cycles, waits and comparison.
   task automatic summarize;
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("CHECK FAILED at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge sys_clk);
      {regWr, regAddr, regWdata} <= {1'b1, a, d};
      @(posedge sys_clk);
      regWr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so sample there.
   task automatic rd(input logic [3:0] a, output logic [15:0] d);
      @(posedge sys_clk);
      {regRd, regAddr} <= {1'b1, a};
      @(posedge sys_clk);
      regRd <= 1'b0;
      #1 d = regRdata;
   endtask
   task automatic wait_est(input logic lvl);
      int i;
      for (i = 0; i < 80 && estimating !== lvl; i++) cyc(1);
      if (i == 80) begin
         n_fail++;
         summarize();
      end
   endtask
   // Mid-run reset, then the stall thresholds again.
   task automatic do_reset;
      {held, floorOn, accel, forward_run_input, reverse_run_input} <= 5'h0;
      rstn <= 1'b0;
      cyc(4);
      rstn <= 1'b1;
      wr(`STG_ADDR_LOWSPD, 16'h0010);
      wr(`STG_ADDR_STALLTQ, 16'h0080);
   endtask
   // ======================================================================
   // Scenarios.
   task automatic t_regs;
      logic [35:0] t [15] = '{{4'h0, 16'h2, 16'h2}, {4'h1, 16'h0, 16'h0}, {4'h2, 16'h3c, 16'h3c},
         {4'h3, 16'h14d, 16'h14d}, {4'h4, 16'h270f, 16'h270f}, {4'h5, 16'h270f, 16'h270f},
         {4'h6, 16'h7, 16'h7}, {4'h0, 16'h0, 16'h2}, {4'h0, 16'h10, 16'h2}, {4'h0, 16'hf, 16'hf},
         {4'h2, 16'h3e9, 16'h3c}, {4'h2, 16'h3e8, 16'h3e8}, {4'h3, 16'h4e21, 16'h14d},
         {4'h6, 16'hc9, 16'h7}, {4'h1, 16'h3, 16'h0}};
      for (int i = 0; i < 15; i++) begin
         if (i > 6) wr(t[i][35:32], t[i][31:16]);
         rd(t[i][35:32], v);
         check(v, t[i][15:0]);
      end
      rd(4'hf, v);
      check(v, 16'h0);
      do_reset();
      $display("register defaults and ranges done");
   endtask
   task automatic t_stall(input logic [3:0] c, input logic byFloor, input logic exp);
      wr(`STG_ADDR_CTRL, {12'h0, c});
      forward_run_input <= 1'b1;
      cyc(4);
      {held, floorOn} <= {!byFloor, byFloor};
      cyc(QUAL - 2);
      {held, floorOn} <= 2'h0;
      cyc(1);
      {held, floorOn} <= {!byFloor, byFloor};
      cyc(QUAL - 2);
      check({15'h0, stall_trip_fault}, 16'h0);
      cyc(8);
      check({15'h0, stall_trip_fault}, {15'h0, exp});
      do_reset();
      $display("stall case %h done", c);
   endtask
   task automatic t_second;
      second_gain_select <= 1'b1;
      cyc(6);
      check(activePropGain, 16'h3c);
      second_gain_select <= 1'b0;
      wr(`STG_ADDR_PG2, 16'h0064);
      wr(`STG_ADDR_IT2, 16'h01f4);
      second_gain_select <= 1'b1;
      cyc(6);
      check(activePropGain, 16'h64);
      check(activeIntegralTime, 16'h1f4);
      second_gain_select <= 1'b0;
      cyc(6);
      check(activeIntegralTime, 16'h14d);
      $display("second gains done");
   endtask
   task automatic t_auto;
      wr(`STG_ADDR_MODE, `STG_MODE_AUTO);
      {reverse_run_input, accel} <= 2'h3;
      wait_est(1'b1);
      cyc(20);
      rd(`STG_ADDR_INERTIA, v);
      check(v, 16'h000c);
      wr(`STG_ADDR_CTRL, {12'h0, `STG_LOOP_SPEED, `STG_DRV_RSV});
      wait_est(1'b0);
      {reverse_run_input, accel} <= 2'h0;
      cyc(4);
      rd(`STG_ADDR_PG1, keep);
      wr(`STG_ADDR_MODE, `STG_MODE_OFF);
      rd(`STG_ADDR_PG1, v);
      check(v, keep);
      do_reset();
      $display("automatic estimation done");
   endtask
   task automatic t_manual;
      wr(`STG_ADDR_INERTIA, 16'h0014);
      wr(`STG_ADDR_CTRL, {12'h0, `STG_LOOP_SPEED, `STG_DRV_RSV});
      wr(`STG_ADDR_MODE, `STG_MODE_MANUAL);
      cyc(6);
      rd(`STG_ADDR_PG1, keep);
      check(activePropGain, keep);
      check({15'h0, keep != `STG_PG_RST}, 16'h1);
      forward_run_key <= 1'b1;
      cyc(4);
      wr(`STG_ADDR_RESP, 16'h0005);
      rd(`STG_ADDR_RESP, v);
      check(v, 16'h0002);
      wr(`STG_ADDR_WPOL, `STG_WPOL_RUNWRITE);
      wr(`STG_ADDR_RESP, 16'h0005);
      rd(`STG_ADDR_RESP, v);
      check(v, 16'h0005);
      forward_run_key <= 1'b0;
      wr(`STG_ADDR_MODE, `STG_MODE_OFF);
      rd(`STG_ADDR_PG1, v);
      check(v, keep);
      $display("manual inertia done");
   endtask
   initial begin
      do_reset();
      t_regs();
      t_stall(4'h3, 1'b0, 1'b1);
      t_stall(4'h7, 1'b0, 1'b0);
      for (int d = 0; d < 4; d++) t_stall(d[3:0], 1'b1, d < 2);
      t_second();
      t_auto();
      t_manual();
      summarize();
   end
endmodule
`default_nettype wire
